// *** core/fspf_top.sv ***
// FIFO serial port: APB registers, 16-byte FIFOs, 16x async engine
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fspf_top #(
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe,
  output logic             rts_o,
  output logic             rts_oe,
  output logic             break_irq_o
);
  localparam logic [7:0] DEPTH8 = 8'(DEPTH);

  logic [7:0]  ctrl_q, fctl_q, baud_q, bcnt_q;
  logic [3:0]  port_q;
  logic        pready_q, pslverr_q, txd_q, txd_oe_q, rts_q, rts_oe_q, bri_q;
  logic [31:0] prdata_q;
  logic        tx_fifo_empty_flag_q, rdf_q, brk_q, overrun_flag_q, brk_act_q;
  logic [7:0]  tx_mem [DEPTH];
  logic [9:0]  rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  logic [7:0]  tx_cnt_q, rx_cnt_q, fer_n_q, per_n_q;
  fspf_pkg::fspf_tx_t tx_st_q;
  fspf_pkg::fspf_rx_t rx_st_q;
  logic [3:0]  tx_tcnt_q, rx_tcnt_q;
  logic [2:0]  tx_bit_q, rx_bit_q;
  logic [7:0]  tx_sh_q, rx_sh_q;
  logic        tx_line_q, rx_prev_q, rx_par_q;

  wire te    = ctrl_q[fspf_pkg::CTRL_TE];
  wire re    = ctrl_q[fspf_pkg::CTRL_RE];
  wire pen   = ctrl_q[fspf_pkg::CTRL_PEN];
  wire podd  = ctrl_q[fspf_pkg::CTRL_PODD];
  wire [7:0] ttrg = fspf_pkg::TTRG_LVL[fctl_q[fspf_pkg::TTRG_LSB +: 2]];
  wire [7:0] rtrg = fspf_pkg::RTRG_LVL[fctl_q[fspf_pkg::RTRG_LSB +: 2]];

  // APB: no wait states; read data is captured into a flop during the setup phase
  wire setup  = psel & ~penable;
  wire acc    = psel & penable & pready_q;
  wire wr     = acc & pwrite & ~pslverr_q;
  wire rd     = acc & ~pwrite & ~pslverr_q;
  wire mapped = paddr inside {fspf_pkg::TXDATA_ADDR, fspf_pkg::RXDATA_ADDR,
                              fspf_pkg::STATUS_ADDR, fspf_pkg::FIFOCTL_ADDR,
                              fspf_pkg::CTRL_ADDR, fspf_pkg::PORT_ADDR,
                              fspf_pkg::COUNT_ADDR, fspf_pkg::BAUD_ADDR};
  wire st_wr  = wr && paddr == fspf_pkg::STATUS_ADDR;

  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[fspf_pkg::ST_TX_FIFO_EMPTY_FLAG]   = tx_fifo_empty_flag_q;
    status[fspf_pkg::ST_RDF]    = rdf_q;
    status[fspf_pkg::ST_FER]    = (fer_n_q != 8'h00) | brk_q;
    status[fspf_pkg::ST_PER]    = per_n_q != 8'h00;
    status[fspf_pkg::ST_BRK]    = brk_q;
    status[fspf_pkg::ST_OVERRUN_FLAG]   = overrun_flag_q;
    status[fspf_pkg::ST_RXPIN]  = rxd_i;
    status[fspf_pkg::ST_TXBUSY] = tx_st_q != fspf_pkg::TX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        case (paddr)
          fspf_pkg::RXDATA_ADDR:  prdata_q <= {22'h00_0000, rx_mem[rx_rp_q]};
          fspf_pkg::STATUS_ADDR:  prdata_q <= {24'h00_0000, status};
          fspf_pkg::FIFOCTL_ADDR: prdata_q <= {24'h00_0000, fctl_q};
          fspf_pkg::CTRL_ADDR:    prdata_q <= {24'h00_0000, ctrl_q};
          fspf_pkg::PORT_ADDR:    prdata_q <= {28'h000_0000, port_q};
          fspf_pkg::COUNT_ADDR:   prdata_q <= {16'h0000, tx_cnt_q, rx_cnt_q};
          fspf_pkg::BAUD_ADDR:    prdata_q <= {24'h00_0000, baud_q};
          default:                prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= fspf_pkg::CTRL_RST;
      fctl_q <= fspf_pkg::FCTL_RST;
      port_q <= fspf_pkg::PORT_RST;
      baud_q <= fspf_pkg::BAUD_RST;
    end else if (wr) begin
      case (paddr)
        fspf_pkg::CTRL_ADDR:    ctrl_q <= pwdata[7:0];
        fspf_pkg::FIFOCTL_ADDR: fctl_q <= pwdata[7:0];
        fspf_pkg::PORT_ADDR:    port_q <= pwdata[3:0];
        fspf_pkg::BAUD_ADDR:    baud_q <= pwdata[7:0];
        default:                ;
      endcase
    end
  end
  // Base tick at 16x bit rate, divided down from pclk
  wire tick = bcnt_q == baud_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bcnt_q <= 8'h00;
    else          bcnt_q <= tick ? 8'h00 : bcnt_q + 8'h01;
  end
  // Transmit FIFO; writes to a full FIFO are dropped
  wire tx_push = wr && paddr == fspf_pkg::TXDATA_ADDR && tx_cnt_q < DEPTH8;
  wire tx_pop  = te && tx_st_q == fspf_pkg::TX_IDLE && tx_cnt_q != 8'h00;
  always_ff @(posedge pclk) begin
    if (tx_push) tx_mem[tx_wp_q] <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= 8'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 1'b1;
      if (tx_pop)  tx_rp_q <= tx_rp_q + 1'b1;
      tx_cnt_q <= tx_cnt_q + 8'(tx_push) - 8'(tx_pop);
    end
  end
  // Transmitter; dropping enable aborts any frame on the spot
  wire tx_end = tick && tx_tcnt_q == fspf_pkg::LAST_TICK;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q   <= fspf_pkg::TX_IDLE;
      tx_line_q <= 1'b1;
      tx_tcnt_q <= 4'h0;
      tx_bit_q  <= 3'h0;
      tx_sh_q   <= 8'h00;
    end else if (!te) begin
      tx_st_q   <= fspf_pkg::TX_IDLE;
      tx_line_q <= 1'b1;
      tx_tcnt_q <= 4'h0;
    end else begin
      tx_tcnt_q <= tx_tcnt_q + 4'(tick);
      case (tx_st_q)
        fspf_pkg::TX_IDLE: begin
          if (tx_pop) begin
            tx_sh_q   <= tx_mem[tx_rp_q];
            tx_line_q <= 1'b0;
            tx_tcnt_q <= 4'h0;
            tx_st_q   <= fspf_pkg::TX_START;
          end
        end
        fspf_pkg::TX_START: begin
          if (tx_end) begin
            tx_line_q <= tx_sh_q[0];
            tx_bit_q  <= 3'h0;
            tx_st_q   <= fspf_pkg::TX_DATA;
          end
        end
        fspf_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_sh_q  <= {tx_sh_q[0], tx_sh_q[7:1]};
            if (tx_bit_q == fspf_pkg::LAST_BIT) begin
              tx_line_q <= pen ? (^tx_sh_q) ^ podd : 1'b1;
              tx_st_q   <= pen ? fspf_pkg::TX_PAR : fspf_pkg::TX_STOP;
            end else begin
              tx_line_q <= tx_sh_q[1];
            end
          end
        end
        fspf_pkg::TX_PAR: begin
          if (tx_end) begin
            tx_line_q <= 1'b1;
            tx_st_q   <= fspf_pkg::TX_STOP;
          end
        end
        fspf_pkg::TX_STOP: begin
          if (tx_end) tx_st_q <= fspf_pkg::TX_IDLE;
        end
        default: tx_st_q <= fspf_pkg::TX_IDLE;
      endcase
    end
  end
  // Receiver: edge found on a tick, bits latched on the 8th tick after
  wire rx_smp  = tick && rx_tcnt_q == fspf_pkg::SAMPLE_TICK;
  wire rx_fend = rx_st_q == fspf_pkg::RX_STOP && rx_smp;
  wire rx_ferr = ~rxd_i;
  wire rx_brkf = rx_fend && rx_ferr && rx_sh_q == 8'h00 && !rx_par_q;
  wire rx_perr = pen && (rx_par_q != ((^rx_sh_q) ^ podd));
  wire rx_full = rx_cnt_q == DEPTH8;
  wire rx_push = rx_fend && !rx_brkf && !brk_act_q && !rx_full;
  wire rx_pop  = rd && paddr == fspf_pkg::RXDATA_ADDR && rx_cnt_q != 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= fspf_pkg::RX_IDLE;
      rx_prev_q <= 1'b1;
      rx_tcnt_q <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
    end else begin
      if (tick) rx_prev_q <= rxd_i;
      rx_tcnt_q <= rx_tcnt_q + 4'(tick);
      case (rx_st_q)
        fspf_pkg::RX_IDLE: begin
          rx_tcnt_q <= 4'h0;
          rx_par_q  <= 1'b0;
          if (re && tick && rx_prev_q && !rxd_i) rx_st_q <= fspf_pkg::RX_START;
        end
        fspf_pkg::RX_START: begin
          if (rx_smp) begin
            rx_bit_q <= 3'h0;
            rx_st_q  <= rxd_i ? fspf_pkg::RX_IDLE : fspf_pkg::RX_DATA;
          end
        end
        fspf_pkg::RX_DATA: begin
          if (rx_smp) begin
            rx_sh_q  <= {rxd_i, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == fspf_pkg::LAST_BIT)
              rx_st_q <= pen ? fspf_pkg::RX_PAR : fspf_pkg::RX_STOP;
          end
        end
        fspf_pkg::RX_PAR: begin
          if (rx_smp) begin
            rx_par_q <= rxd_i;
            rx_st_q  <= fspf_pkg::RX_STOP;
          end
        end
        fspf_pkg::RX_STOP: begin
          if (rx_smp) rx_st_q <= fspf_pkg::RX_IDLE;
        end
        default: rx_st_q <= fspf_pkg::RX_IDLE;
      endcase
    end
  end
  // Receive FIFO; each word carries its own error bits
  wire [9:0] rx_head = rx_mem[rx_rp_q];
  always_ff @(posedge pclk) begin
    if (rx_push) rx_mem[rx_wp_q] <= {rx_perr, rx_ferr, rx_sh_q};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= 8'h00;
      fer_n_q  <= 8'h00;
      per_n_q  <= 8'h00;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + 1'b1;
      if (rx_pop)  rx_rp_q <= rx_rp_q + 1'b1;
      rx_cnt_q <= rx_cnt_q + 8'(rx_push) - 8'(rx_pop);
      // Error flags count faulty words still queued, so a read clears them
      fer_n_q <= fer_n_q + 8'(rx_push & rx_ferr)
               - 8'(rx_pop & rx_head[fspf_pkg::RXW_FER]);
      per_n_q <= per_n_q + 8'(rx_push & rx_perr)
               - 8'(rx_pop & rx_head[fspf_pkg::RXW_PER]);
    end
  end
  // Status flags: hardware set wins over a software clear in the same cycle
  wire clr_tx_fifo_empty_flag = st_wr && !pwdata[fspf_pkg::ST_TX_FIFO_EMPTY_FLAG];
  wire clr_rdf  = st_wr && !pwdata[fspf_pkg::ST_RDF];
  wire clr_brk  = st_wr && !pwdata[fspf_pkg::ST_BRK];
  wire clr_overrun_flag = st_wr && !pwdata[fspf_pkg::ST_OVERRUN_FLAG];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fifo_empty_flag_q    <= 1'b0;
      rdf_q     <= 1'b0;
      brk_q     <= 1'b0;
      overrun_flag_q    <= 1'b0;
      brk_act_q <= 1'b0;
    end else begin
      tx_fifo_empty_flag_q    <= (tx_cnt_q < ttrg)
                 | (tx_fifo_empty_flag_q & ~clr_tx_fifo_empty_flag)
                 | (tx_fifo_empty_flag_q & clr_tx_fifo_empty_flag & tx_cnt_q <= ttrg);
      rdf_q     <= (rx_cnt_q >= rtrg) | (rdf_q & ~clr_rdf);
      brk_q     <= rx_brkf | (brk_q & ~clr_brk);
      overrun_flag_q    <= (rx_fend && !rx_brkf && !brk_act_q && rx_full)
                 | (overrun_flag_q & ~clr_overrun_flag);
      // Break ends only when the line returns to mark
      brk_act_q <= rx_brkf | (brk_act_q & ~rxd_i);
    end
  end

  // Pins: transmitter owns the pin only while enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_q    <= 1'b1;
      txd_oe_q <= 1'b0;
      rts_q    <= 1'b1;
      rts_oe_q <= 1'b0;
      bri_q    <= 1'b0;
    end else begin
      txd_q    <= te ? tx_line_q : port_q[fspf_pkg::PORT_TX_PIN_LEVEL_BIT];
      txd_oe_q <= te | port_q[fspf_pkg::PORT_TX_PIN_DIRECTION_BIT];
      rts_q    <= port_q[fspf_pkg::PORT_REQUEST_SEND_LEVEL_BIT];
      rts_oe_q <= port_q[fspf_pkg::PORT_REQUEST_SEND_DIRECTION_BIT];
      bri_q    <= (brk_q | overrun_flag_q)
                & (ctrl_q[fspf_pkg::CTRL_RIE] | ctrl_q[fspf_pkg::CTRL_RECEIVE_ERROR_INTERRUPT_ENABLE]);
    end
  end
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign txd_o       = txd_q;
  assign txd_oe      = txd_oe_q;
  assign rts_o       = rts_q;
  assign rts_oe      = rts_oe_q;
  assign break_irq_o = bri_q;
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_TX_FIFO_EMPTY_FLAG_SET: assert property (tx_cnt_q < ttrg |=> tx_fifo_empty_flag_q)
    else $error("tx empty flag not set below trigger");
  AST_TX_FIFO_EMPTY_FLAG_RESET: assert property (
    tx_fifo_empty_flag_q && clr_tx_fifo_empty_flag && tx_cnt_q <= ttrg |=> tx_fifo_empty_flag_q)
    else $error("tx empty flag lost at clear");
  AST_RDF_HOLD: assert property (rx_cnt_q >= rtrg |=> rdf_q)
    else $error("rx full flag not held at trigger");
  AST_COUNT_RD: assert property (setup && paddr == fspf_pkg::COUNT_ADDR
    |=> prdata_q[15:8] == $past(tx_cnt_q) && prdata_q[7:0] == $past(rx_cnt_q))
    else $error("count register mismatch");
  AST_BRK_NOPUSH: assert property (brk_act_q |=> rx_cnt_q <= $past(rx_cnt_q))
    else $error("char stored during break");
  AST_TE_OFF: assert property (!te |=> tx_st_q == fspf_pkg::TX_IDLE
    ##0 txd_q == $past(port_q[fspf_pkg::PORT_TX_PIN_LEVEL_BIT]))
    else $error("transmitter not reset when disabled");
  AST_START_NOW: assert property (tx_pop |=> !tx_line_q ##1 (!txd_q || !$past(te)))
    else $error("start bit delayed");
  AST_BRI: assert property (##1 bri_q == $past((brk_q | overrun_flag_q)
    & (ctrl_q[fspf_pkg::CTRL_RIE] | ctrl_q[fspf_pkg::CTRL_RECEIVE_ERROR_INTERRUPT_ENABLE])))
    else $error("break interrupt mismatch");
  AST_OVERRUN: assert property (rx_fend && !rx_brkf && !brk_act_q && rx_full
    |=> overrun_flag_q && rx_cnt_q == DEPTH8 - 8'($past(rx_pop)))
    else $error("overrun not flagged");
  COV_TX_FRAME: cover property (tx_pop ##[1:1000] tx_st_q == fspf_pkg::TX_STOP);
  COV_RX_PUSH: cover property (rx_push);
  COV_BREAK: cover property (rx_brkf);
endmodule

// *** core/fspf_pkg.sv ***
// Shared constants for the FIFO serial port block
package fspf_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 8;
  // Register byte addresses
  localparam logic [7:0]  TXDATA_ADDR  = 8'h00;
  localparam logic [7:0]  RXDATA_ADDR  = 8'h04;
  localparam logic [7:0]  STATUS_ADDR  = 8'h08;
  localparam logic [7:0]  FIFOCTL_ADDR = 8'h0c;
  localparam logic [7:0]  CTRL_ADDR    = 8'h10;
  localparam logic [7:0]  PORT_ADDR    = 8'h14;
  localparam logic [7:0]  COUNT_ADDR   = 8'h18;
  localparam logic [7:0]  BAUD_ADDR    = 8'h1c;
  // Control register bits
  localparam int          CTRL_TE      = 0;
  localparam int          CTRL_RE      = 1;
  localparam int          CTRL_RIE     = 2;
  localparam int          CTRL_RECEIVE_ERROR_INTERRUPT_ENABLE    = 3;
  localparam int          CTRL_PEN     = 4;
  localparam int          CTRL_PODD    = 5;
  // FIFO control fields
  localparam int          TTRG_LSB     = 4;
  localparam int          RTRG_LSB     = 6;
  // Serial port register bits
  localparam int          PORT_TX_PIN_LEVEL_BIT   = 0;
  localparam int          PORT_TX_PIN_DIRECTION_BIT   = 1;
  localparam int          PORT_REQUEST_SEND_LEVEL_BIT   = 2;
  localparam int          PORT_REQUEST_SEND_DIRECTION_BIT   = 3;
  // Status register bits
  localparam int          ST_TX_FIFO_EMPTY_FLAG      = 0;
  localparam int          ST_RDF       = 1;
  localparam int          ST_FER       = 2;
  localparam int          ST_PER       = 3;
  localparam int          ST_BRK       = 4;
  localparam int          ST_OVERRUN_FLAG      = 5;
  localparam int          ST_RXPIN     = 6;
  localparam int          ST_TXBUSY    = 7;
  // Received word layout
  localparam int          RXW_FER      = 8;
  localparam int          RXW_PER      = 9;
  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  FCTL_RST     = 8'h00;
  localparam logic [3:0]  PORT_RST     = 4'h0;
  localparam logic [7:0]  BAUD_RST     = 8'h00;
  // Oversampling: 16 base ticks per bit, data latched on the 8th
  localparam int          OVERSAMPLE   = 16;
  localparam logic [3:0]  SAMPLE_TICK  = 4'h7;
  localparam logic [3:0]  LAST_TICK    = 4'(OVERSAMPLE - 1);
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  // Trigger levels indexed by the two trigger bits
  localparam logic [7:0]  TTRG_LVL [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
  localparam logic [7:0]  RTRG_LVL [4] = '{8'h0e, 8'h08, 8'h04, 8'h01};
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fspf_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fspf_rx_t;
endpackage

// *** bench/fspf_remote_uart.sv ***
// Remote serial device model: frames onto receive line, decodes transmit line
`timescale 1ns/1ps
module fspf_remote_uart #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic pclk,
  input  wire logic txd_line,
  output logic      rxd
);
  logic [7:0] rx_byte;
  int         rx_count;

  initial begin
    rxd = 1'b1;
    rx_byte = 8'h00;
    rx_count = 0;
  end

  // Start low, data LSB first, caller picks the stop level
  task automatic send_frame(input logic [7:0] b, input logic stop_lvl);
    logic [9:0] f;
    f = {stop_lvl, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge pclk);
    end
  endtask

  // Long low level here is a break
  task automatic hold(input logic lvl, input int bits);
    rxd <= lvl;
    repeat (bits * BIT_CLKS) @(posedge pclk);
  endtask

  // Sampled on falling pclk so the block's edge updates have landed
  initial begin
    forever begin
      @(negedge txd_line);
      repeat (BIT_CLKS / 2) @(negedge pclk);
      if (txd_line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(negedge pclk);
          rx_byte[i] = txd_line;
        end
        repeat (BIT_CLKS) @(negedge pclk);
        if (txd_line === 1'b1) begin
          rx_count++;
        end
      end
    end
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the FIFO serial port block
`timescale 1ns/1ps
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd_i;
  logic        txd_o;
  logic        txd_oe;
  logic        rts_o;
  logic        rts_oe;
  logic        break_irq_o;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          checks_done;
  int          cycles = 0;
  // Pull-up assumed on the pin while the block releases it
  wire         txd_line = txd_oe ? txd_o : 1'b1;

  fspf_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_i(rxd_i), .txd_o(txd_o),
    .txd_oe(txd_oe), .rts_o(rts_o), .rts_oe(rts_oe), .break_irq_o(break_irq_o)
  );
  fspf_remote_uart u_remote (.pclk(pclk), .txd_line(txd_line), .rxd(rxd_i));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run needs well under 20000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Pin order: rts_oe, rts_o, txd_oe, txd_o
  task automatic pins(input logic [3:0] e);
    repeat (2) @(negedge pclk);
    chk({28'h0, rts_oe, rts_o, txd_oe, txd_o}, {28'h0, e});
    @(posedge pclk);
  endtask

  task automatic t_reset;
    rdm(fspf_pkg::CTRL_ADDR, 32'hff, {24'h0, fspf_pkg::CTRL_RST});
    rdm(fspf_pkg::PORT_ADDR, 32'hf, {28'h0, fspf_pkg::PORT_RST});
    rdm(fspf_pkg::FIFOCTL_ADDR, 32'hff, {24'h0, fspf_pkg::FCTL_RST});
    rdm(fspf_pkg::COUNT_ADDR, 32'hffff, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h1, 32'h1);
    rdm(8'h20, 32'hffffffff, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_tx;
    int n;
    wr(fspf_pkg::PORT_ADDR, 32'hb);
    pins(4'hb);
    // Tx and rx trigger both four
    wr(fspf_pkg::FIFOCTL_ADDR, 32'ha0);
    for (int i = 0; i < 4; i++) wr(fspf_pkg::TXDATA_ADDR, 32'h35 + i);
    rdm(fspf_pkg::COUNT_ADDR, 32'hffff, 32'h0400);
    wr(fspf_pkg::STATUS_ADDR, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h1, 32'h1);
    for (int i = 4; i < 17; i++) wr(fspf_pkg::TXDATA_ADDR, 32'h35 + i);
    rdm(fspf_pkg::COUNT_ADDR, 32'hffff, 32'h1000);
    wr(fspf_pkg::STATUS_ADDR, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h1, 32'h0);
    wr(fspf_pkg::CTRL_ADDR, 32'h1);
    n = 0;
    while (txd_o !== 1'b0 && n < 4) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, txd_o}, 32'h0);
    @(posedge pclk);
    while (u_remote.rx_count < 1) @(posedge pclk);
    chk({24'h0, u_remote.rx_byte}, 32'h35);
    // Land the abort inside the second frame
    repeat (40) @(posedge pclk);
    wr(fspf_pkg::PORT_ADDR, 32'ha);
    wr(fspf_pkg::CTRL_ADDR, 32'h0);
    pins(4'ha);
    wr(fspf_pkg::PORT_ADDR, 32'hb);
    pins(4'hb);
  endtask

  task automatic t_rx_flags;
    wr(fspf_pkg::CTRL_ADDR, 32'h6);
    for (int i = 0; i < 3; i++) u_remote.send_frame(8'hc0 + 8'(i), 1'b1);
    repeat (4) @(posedge pclk);
    rdm(fspf_pkg::COUNT_ADDR, 32'hff, 32'h3);
    rdm(fspf_pkg::STATUS_ADDR, 32'h2, 32'h0);
    u_remote.send_frame(8'hc3, 1'b1);
    repeat (4) @(posedge pclk);
    rdm(fspf_pkg::STATUS_ADDR, 32'h2, 32'h2);
    wr(fspf_pkg::STATUS_ADDR, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h2, 32'h2);
    for (int i = 0; i < 4; i++) rdm(fspf_pkg::RXDATA_ADDR, 32'h3ff, 32'hc0 + i);
    rdm(fspf_pkg::COUNT_ADDR, 32'hff, 32'h0);
    wr(fspf_pkg::STATUS_ADDR, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h2, 32'h0);
  endtask

  task automatic t_frame_err;
    // Rx trigger fourteen keeps the full flag low while the error is inspected
    wr(fspf_pkg::FIFOCTL_ADDR, 32'h0);
    u_remote.send_frame(8'h5a, 1'b0);
    u_remote.hold(1'b1, 2);
    rdm(fspf_pkg::STATUS_ADDR, 32'h6, 32'h4);
    rdm(fspf_pkg::RXDATA_ADDR, 32'h3ff, 32'h15a);
    rdm(fspf_pkg::STATUS_ADDR, 32'h4, 32'h0);
  endtask

  task automatic t_parity;
    wr(fspf_pkg::CTRL_ADDR, 32'h16);
    // Tenth slot carries the parity bit; even parity wants a one here
    u_remote.send_frame(8'h01, 1'b0);
    u_remote.hold(1'b1, 2);
    rdm(fspf_pkg::STATUS_ADDR, 32'hc, 32'h8);
    rdm(fspf_pkg::RXDATA_ADDR, 32'h3ff, 32'h201);
    rdm(fspf_pkg::STATUS_ADDR, 32'h8, 32'h0);
    wr(fspf_pkg::CTRL_ADDR, 32'h6);
  endtask

  task automatic t_break;
    u_remote.hold(1'b0, 30);
    rdm(fspf_pkg::STATUS_ADDR, 32'h14, 32'h14);
    rdm(fspf_pkg::COUNT_ADDR, 32'hff, 32'h0);
    chk({31'h0, break_irq_o}, 32'h1);
    u_remote.hold(1'b1, 2);
    wr(fspf_pkg::STATUS_ADDR, 32'h0);
    rdm(fspf_pkg::STATUS_ADDR, 32'h14, 32'h0);
    chk({31'h0, break_irq_o}, 32'h0);
    // Receiver must still work once the line is back
    u_remote.send_frame(8'h3c, 1'b1);
    repeat (4) @(posedge pclk);
    rdm(fspf_pkg::RXDATA_ADDR, 32'h3ff, 32'h3c);
  endtask

  task automatic t_overrun;
    for (int i = 0; i < 17; i++) u_remote.send_frame(8'h80 + 8'(i), 1'b1);
    repeat (4) @(posedge pclk);
    rdm(fspf_pkg::COUNT_ADDR, 32'hff, 32'h10);
    rdm(fspf_pkg::STATUS_ADDR, 32'h20, 32'h20);
    chk({31'h0, break_irq_o}, 32'h1);
    for (int i = 0; i < 16; i++) rdm(fspf_pkg::RXDATA_ADDR, 32'h3ff, 32'h80 + i);
  endtask

  initial begin
    miscompares = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    chk({27'h0, break_irq_o, rts_oe, rts_o, txd_oe, txd_o}, 32'h5);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tx();
    t_rx_flags();
    t_frame_err();
    t_parity();
    t_break();
    t_overrun();
    report_and_stop();
  end
endmodule
